// ---- design/ctp_pkg.sv ----
// constants and types shared by the compact timer design
// assumes a single system clock domain and an AXI4-Lite register bus with 32-bit data

package ctp_pkg;

	// ------------------------------------------------------------
	// bus geometry and answers
	// ------------------------------------------------------------
	localparam int unsigned CTP_DATA_W = 32;
	localparam int unsigned CTP_ADDR_W = 6;
	localparam int unsigned CTP_COUNT_W = 16;

	localparam logic [1:0] CTP_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CTP_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_CTRL_FIRST  = 6'h00;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_CTRL_SECOND = 6'h04;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_COUNT_LOW   = 6'h08;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_COUNT_HIGH  = 6'h0C;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_CMPA_LOW    = 6'h10;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_CMPA_HIGH   = 6'h14;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_PERIOD      = 6'h18;
	localparam logic [CTP_ADDR_W-1:0] CTP_OFF_FLAGS       = 6'h1C;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0]  CTP_RST_BYTE    = 8'h00;
	localparam logic [15:0] CTP_RST_WORD    = 16'h0000;
	localparam logic [2:0]  CTP_UNUSED_BITS = 3'h0;
	localparam int unsigned CTP_FLAG_A_BIT  = 0;
	localparam int unsigned CTP_FLAG_P_BIT  = 1;

	// ------------------------------------------------------------
	// clock prescaling
	// ------------------------------------------------------------
	localparam logic [1:0] CTP_SYS_DIV4_LAST = 2'h3;
	localparam logic [5:0] CTP_HIGH_MASK16   = 6'h0F;
	localparam logic [5:0] CTP_HIGH_MASK64   = 6'h3F;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CTP_MODE_COMPARE = 2'b00,
		CTP_MODE_UNDEF   = 2'b01,
		CTP_MODE_PWM     = 2'b10,
		CTP_MODE_TIMER   = 2'b11
	} ctp_mode_t;

	typedef enum logic [2:0] {
		CTP_CLK_SYS_DIV4 = 3'b000,
		CTP_CLK_SYS      = 3'b001,
		CTP_CLK_HIGH16   = 3'b010,
		CTP_CLK_HIGH64   = 3'b011,
		CTP_CLK_SUB_A    = 3'b100,
		CTP_CLK_SUB_B    = 3'b101,
		CTP_CLK_EXT_RISE = 3'b110,
		CTP_CLK_EXT_FALL = 3'b111
	} ctp_clk_sel_t;

	typedef enum logic [1:0] {
		CTP_FN_NONE   = 2'b00,
		CTP_FN_LOW    = 2'b01,
		CTP_FN_HIGH   = 2'b10,
		CTP_FN_TOGGLE = 2'b11
	} ctp_out_fn_t;

	typedef struct packed {
		logic         pause_control;
		ctp_clk_sel_t clock_source_select;
		logic         counter_on;
		logic [2:0]   unused;
	} ctp_ctrl_first_t;

	typedef struct packed {
		ctp_mode_t   operating_mode_select;
		ctp_out_fn_t output_function_select;
		logic        output_initial_level;
		logic        output_invert;
		logic        duty_period_swap;
		logic        clear_source_select;
	} ctp_ctrl_second_t;

endpackage

// ---- design/ctp_timer.sv ----
// compact 16-bit timer with compare output and edge pwm, registers over AXI4-Lite
// assumes one 40 MHz system clock; the high, sub and external clock pins are asynchronous levels
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - 16-bit up-counter advanced by selected clock, readable but never writable.
// - comparator A matches when all sixteen counter bits equal its value, if that value is nonzero.
// - comparator P matches when counter upper byte equals its 8-bit value and lower byte is zero.
// - software alters the counter only by an on-bit rising edge, clearing it.
// - counter self-clears on overflow or selected match, raising request flags.
// - pause holds the count; releasing pause resumes from the held value.
// - clock select: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// - on bit low stops counting; count kept until on goes high again.
// - on-bit rising edge returns output to initial level in compare or pwm mode.
// - first control register bits 2..0 always read zero.
// - mode 00 compare output, 10 pwm, 11 timer/counter, 01 undefined.
// - compare mode A match: 00 hold, 01 low, 10 high, 11 toggle.
// - pwm mode function: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - initial-level bit: pre-match level in compare, active level in pwm.
// - match requesting the already present level leaves the pin unchanged.
// - invert bit inverts the pin; no effect in timer/counter mode.
// - swap bit 0: P period, A duty; 1: A period, P duty.
// - clear source 1 clears on A match; 0 on P match or overflow.
// - overflow clearing with P source only when P value is zero.
// - clear source ignored in pwm; pin undefined in timer/counter mode.
// - P value zero gives 65536-clock period, else 256 times value.
// - with clear source A outside pwm mode only the A flag is raised, never P.
// - compare mode pin reacts to A matches only, never to P.
// - low bytes pass through an 8-bit buffer moved on high-byte access.
module ctp_timer
	import ctp_pkg::*;
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ctp_pkg::CTP_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ctp_pkg::CTP_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ctp_pkg::CTP_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [ctp_pkg::CTP_DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          high_internal_clock,
	input  wire logic                          sub_clock,
	input  wire logic                          external_clock_pin,
	output logic                               timer_output_pin,
	output logic                               timer_output_pin_oe
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	ctp_ctrl_first_t         ctrl_first_q;
	ctp_ctrl_second_t        ctrl_second_q;
	logic [CTP_COUNT_W-1:0]  count_q;
	logic [CTP_COUNT_W-1:0]  count_next;
	logic [CTP_COUNT_W-1:0]  cmpa_q;
	logic [7:0]              cmpp_q;
	logic [7:0]              buf_q;
	logic [1:0]              flags_q;
	logic                    on_prev_q;
	logic [2:0]              sync1_q;
	logic [2:0]              sync2_q;
	logic [2:0]              sync3_q;
	logic [1:0]              sys_pre_q;
	logic [5:0]              high_pre_q;
	logic                    level_q;
	logic                    pwm_active_q;
	logic                    pin_q;
	logic                    pin_oe_q;
	logic                    aw_have_q;
	logic                    w_have_q;
	logic [CTP_ADDR_W-1:0]   awaddr_q;
	logic [7:0]              wbyte_q;
	logic                    wstrb0_q;
	logic                    awready_q;
	logic                    wready_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic                    arready_q;
	logic                    rvalid_q;
	logic [CTP_DATA_W-1:0]   rdata_q;
	logic [1:0]              rresp_q;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    wr_mapped;
	logic                    rd_mapped;
	logic [7:0]              rd_byte;
	logic                    on_rise;
	logic                    run;
	logic                    tick;
	logic                    high_edge;
	logic                    sub_edge;
	logic                    ext_rise;
	logic                    ext_fall;
	logic                    a_hit;
	logic                    p_hit;
	logic                    clr_hit;
	logic                    duty_hit;
	logic                    is_pwm;
	logic [1:0]              flag_set;
	logic [1:0]              flag_clr;
	logic                    pin_lvl;
	logic                    pin_oe;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [CTP_ADDR_W-1:0] addr, input logic [CTP_ADDR_W-1:0] off);
		reg_hit = (addr[CTP_ADDR_W-1:2] == off[CTP_ADDR_W-1:2]);
	endfunction

	function automatic logic is_mapped(input logic [CTP_ADDR_W-1:0] addr);
		is_mapped = (addr[CTP_ADDR_W-1:2] <= CTP_OFF_FLAGS[CTP_ADDR_W-1:2]);
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_mapped = is_mapped(awaddr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awaddr_q  <= '0;
			awready_q <= 1'b0;
		end else if (s_axi_awvalid && awready_q) begin
			aw_have_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
			awready_q <= 1'b0;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end else if (!aw_have_q && !bvalid_q) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wbyte_q  <= CTP_RST_BYTE;
			wstrb0_q <= 1'b0;
			wready_q <= 1'b0;
		end else if (s_axi_wvalid && wready_q) begin
			w_have_q <= 1'b1;
			wbyte_q  <= s_axi_wdata[7:0];
			wstrb0_q <= s_axi_wstrb[0];
			wready_q <= 1'b0;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end else if (!w_have_q && !bvalid_q) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= CTP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? CTP_RESP_OKAY : CTP_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	assign rd_fire = s_axi_arvalid && arready_q;
	assign rd_mapped = is_mapped(s_axi_araddr);

	always_comb begin
		rd_byte = CTP_RST_BYTE;
		if (reg_hit(s_axi_araddr, CTP_OFF_CTRL_FIRST))
			rd_byte = {ctrl_first_q[7:3], CTP_UNUSED_BITS};
		else if (reg_hit(s_axi_araddr, CTP_OFF_CTRL_SECOND))
			rd_byte = ctrl_second_q;
		else if (reg_hit(s_axi_araddr, CTP_OFF_COUNT_LOW) || reg_hit(s_axi_araddr, CTP_OFF_CMPA_LOW))
			rd_byte = buf_q;
		else if (reg_hit(s_axi_araddr, CTP_OFF_COUNT_HIGH))
			rd_byte = count_q[15:8];
		else if (reg_hit(s_axi_araddr, CTP_OFF_CMPA_HIGH))
			rd_byte = cmpa_q[15:8];
		else if (reg_hit(s_axi_araddr, CTP_OFF_PERIOD))
			rd_byte = cmpp_q;
		else if (reg_hit(s_axi_araddr, CTP_OFF_FLAGS))
			rd_byte = {6'h00, flags_q};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= CTP_RESP_OKAY;
		end else if (rd_fire) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= {24'h000000, rd_byte};
			rresp_q   <= rd_mapped ? CTP_RESP_OKAY : CTP_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// control and compare registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_first_q  <= ctp_ctrl_first_t'(CTP_RST_BYTE);
			ctrl_second_q <= ctp_ctrl_second_t'(CTP_RST_BYTE);
			cmpp_q        <= CTP_RST_BYTE;
		end else if (wr_fire && wstrb0_q) begin
			if (reg_hit(awaddr_q, CTP_OFF_CTRL_FIRST))
				ctrl_first_q <= ctp_ctrl_first_t'({wbyte_q[7:3], CTP_UNUSED_BITS});
			if (reg_hit(awaddr_q, CTP_OFF_CTRL_SECOND))
				ctrl_second_q <= ctp_ctrl_second_t'(wbyte_q);
			if (reg_hit(awaddr_q, CTP_OFF_PERIOD))
				cmpp_q <= wbyte_q;
		end
	end

	// low byte moves through the shared buffer on high-byte access
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmpa_q <= CTP_RST_WORD;
			buf_q  <= CTP_RST_BYTE;
		end else if (wr_fire && wstrb0_q && reg_hit(awaddr_q, CTP_OFF_CMPA_LOW)) begin
			buf_q <= wbyte_q;
		end else if (wr_fire && wstrb0_q && reg_hit(awaddr_q, CTP_OFF_CMPA_HIGH)) begin
			cmpa_q <= {wbyte_q, buf_q};
		end else if (rd_fire && reg_hit(s_axi_araddr, CTP_OFF_COUNT_HIGH)) begin
			buf_q <= count_q[7:0];
		end else if (rd_fire && reg_hit(s_axi_araddr, CTP_OFF_CMPA_HIGH)) begin
			buf_q <= cmpa_q[7:0];
		end
	end

	// ------------------------------------------------------------
	// clock source selection
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= {external_clock_pin, sub_clock, high_internal_clock};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign high_edge = sync2_q[0] && !sync3_q[0];
	assign sub_edge  = sync2_q[1] && !sync3_q[1];
	assign ext_rise  = sync2_q[2] && !sync3_q[2];
	assign ext_fall  = !sync2_q[2] && sync3_q[2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_pre_q  <= 2'h0;
			high_pre_q <= 6'h00;
		end else begin
			sys_pre_q <= sys_pre_q + 2'h1;
			if (high_edge)
				high_pre_q <= high_pre_q + 6'h01;
		end
	end

	always_comb begin
		case (ctrl_first_q.clock_source_select)
			CTP_CLK_SYS_DIV4: tick = (sys_pre_q == CTP_SYS_DIV4_LAST);
			CTP_CLK_SYS:      tick = 1'b1;
			CTP_CLK_HIGH16:   tick = high_edge && ((high_pre_q & CTP_HIGH_MASK16) == CTP_HIGH_MASK16);
			CTP_CLK_HIGH64:   tick = high_edge && (high_pre_q == CTP_HIGH_MASK64);
			CTP_CLK_SUB_A, CTP_CLK_SUB_B: tick = sub_edge;
			CTP_CLK_EXT_RISE: tick = ext_rise;
			CTP_CLK_EXT_FALL: tick = ext_fall;
			default:          tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// counter and comparators
	// ------------------------------------------------------------
	assign run        = ctrl_first_q.counter_on && !ctrl_first_q.pause_control;
	assign on_rise    = ctrl_first_q.counter_on && !on_prev_q;
	assign count_next = count_q + 16'h0001;
	assign is_pwm     = (ctrl_second_q.operating_mode_select == CTP_MODE_PWM);

	// a zero A value never matches; the counter then just wraps
	assign a_hit = run && tick && (cmpa_q != CTP_RST_WORD) && (count_next == cmpa_q);
	// P value zero turns into the 16-bit overflow
	assign p_hit = run && tick && (count_next == {cmpp_q, 8'h00});

	always_comb begin
		if (is_pwm) begin
			clr_hit  = ctrl_second_q.duty_period_swap ? a_hit : p_hit;
			duty_hit = ctrl_second_q.duty_period_swap ? p_hit : a_hit;
		end else begin
			clr_hit  = ctrl_second_q.clear_source_select ? a_hit : p_hit;
			duty_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			on_prev_q <= 1'b0;
		else
			on_prev_q <= ctrl_first_q.counter_on;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_q <= CTP_RST_WORD;
		else if (on_rise)
			count_q <= CTP_RST_WORD;
		else if (clr_hit)
			count_q <= CTP_RST_WORD;
		else if (run && tick)
			count_q <= count_next;
	end

	// ------------------------------------------------------------
	// match flags
	// ------------------------------------------------------------
	assign flag_set[CTP_FLAG_A_BIT] = a_hit;
	assign flag_set[CTP_FLAG_P_BIT] = p_hit && (is_pwm || !ctrl_second_q.clear_source_select);
	assign flag_clr = (wr_fire && wstrb0_q && reg_hit(awaddr_q, CTP_OFF_FLAGS)) ? wbyte_q[1:0] : 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			flags_q <= 2'h0;
		else
			flags_q <= (flags_q & ~flag_clr) | flag_set;
	end

	// ------------------------------------------------------------
	// output pin
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_q <= 1'b0;
		end else if (on_rise) begin
			level_q <= ctrl_second_q.output_initial_level;
		end else if (a_hit && !is_pwm) begin
			case (ctrl_second_q.output_function_select)
				CTP_FN_LOW:    level_q <= 1'b0;
				CTP_FN_HIGH:   level_q <= 1'b1;
				CTP_FN_TOGGLE: level_q <= !level_q;
				default:       level_q <= level_q;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pwm_active_q <= 1'b0;
		else if (on_rise || (is_pwm && clr_hit))
			pwm_active_q <= 1'b1;
		else if (duty_hit)
			pwm_active_q <= 1'b0;
	end

	always_comb begin
		pin_lvl = 1'b0;
		pin_oe  = 1'b1;
		case (ctrl_second_q.operating_mode_select)
			CTP_MODE_COMPARE: pin_lvl = level_q;
			CTP_MODE_PWM: begin
				case (ctrl_second_q.output_function_select)
					CTP_FN_NONE: pin_lvl = !ctrl_second_q.output_initial_level;
					CTP_FN_LOW:  pin_lvl = ctrl_second_q.output_initial_level;
					CTP_FN_HIGH: pin_lvl = pwm_active_q ^ !ctrl_second_q.output_initial_level;
					default:     pin_lvl = !ctrl_second_q.output_initial_level;
				endcase
			end
			default: pin_oe = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q    <= 1'b0;
			pin_oe_q <= 1'b0;
		end else begin
			pin_q    <= pin_oe && (pin_lvl ^ ctrl_second_q.output_invert);
			pin_oe_q <= pin_oe;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready       = awready_q;
	assign s_axi_wready        = wready_q;
	assign s_axi_bvalid        = bvalid_q;
	assign s_axi_bresp         = bresp_q;
	assign s_axi_arready       = arready_q;
	assign s_axi_rvalid        = rvalid_q;
	assign s_axi_rdata         = rdata_q;
	assign s_axi_rresp         = rresp_q;
	assign timer_output_pin    = pin_q;
	assign timer_output_pin_oe = pin_oe_q;

endmodule

// ---- verification/ctp_timer_checker.sv ----
// concurrent checks on the compact timer register bus and output pin
// assumes a bind to ctp_timer with one aclk domain
`timescale 1ns/1ps
module ctp_timer_checker
	import ctp_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [5:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_pin_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after request");
	AST_RD_HOLD: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
	AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready)
		else $error("read answer not released");
	AST_WR_HOLD: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");
	AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	AST_CTRL_ZERO: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CTP_OFF_CTRL_FIRST
		|=> s_axi_rdata[2:0] == CTP_UNUSED_BITS) else $error("unused control bits not zero");
	AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 6'h20
		|=> s_axi_rresp == CTP_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	AST_OE_LOW: assert property (!timer_output_pin_oe |-> !timer_output_pin)
		else $error("pin level while released");
	CV_READ: cover property (s_axi_rvalid && s_axi_rready);
	CV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
	CV_PIN: cover property ($rose(timer_output_pin));
endmodule
bind ctp_timer ctp_timer_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_output_pin, .timer_output_pin_oe);

// ---- verification/ctp_pin_model.sv ----
// board side of the compact timer: clock sources, external clock pin, loaded output pin
// assumes the bench calls pulse() to send edges on the external clock pin
`timescale 1ns/1ps
module ctp_pin_model (
	output logic      high_internal_clock,
	output logic      sub_clock,
	output logic      external_clock_pin,
	input  wire logic timer_output_pin,
	input  wire logic timer_output_pin_oe,
	output logic      board_level
);
	// free-running sources, unrelated in phase to aclk
	initial begin
		high_internal_clock = 1'h0;
		forever #26 high_internal_clock = ~high_internal_clock;
	end
	initial begin
		sub_clock = 1'h0;
		forever #251 sub_clock = ~sub_clock;
	end
	initial external_clock_pin = 1'h0;
	// pull-down on the board holds a released pin low
	assign board_level = timer_output_pin_oe ? timer_output_pin : 1'h0;
	// external pin idles low between bursts
	task automatic pulse(input int n);
		repeat (n) begin
			#200 external_clock_pin = 1'h1;
			#200 external_clock_pin = 1'h0;
		end
	endtask
endmodule

// ---- verification/tb_ctp_timer.sv ----
// self-checking bench for the compact timer over its register bus
// assumes ctp_pkg, ctp_timer, its checker and ctp_pin_model are compiled first
`timescale 1ns/1ps
module tb_ctp_timer;
	import ctp_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        high_internal_clock, sub_clock, external_clock_pin, timer_output_pin, timer_output_pin_oe;
	logic        board_level, e;
	logic [15:0] v, w;
	int          bad_count, check_count, cyc, n;
	int          lo[8] = '{45, 190, 5, 1, 9, 9, 8, 8};
	int          hi[8] = '{56, 215, 7, 2, 11, 11, 8, 8};
	logic [1:0]  fv[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	logic        sw[4] = '{1'h0, 1'h0, 1'h0, 1'h1};
	logic [7:0]  ah[4] = '{8'h00, 8'h00, 8'h00, 8'h02};
	logic [7:0]  al[4] = '{8'h40, 8'h40, 8'h40, 8'h00};
	int          act[4] = '{0, 512, 128, 256};

	ctp_timer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_internal_clock, .sub_clock, .external_clock_pin,
		.timer_output_pin, .timer_output_pin_oe);
	ctp_pin_model u_pin (.high_internal_clock, .sub_clock, .external_clock_pin, .timer_output_pin,
		.timer_output_pin_oe, .board_level);

	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end
	// ------------------------------------------------------------
	// bus tasks and checks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] l, input logic [31:0] h, input logic [31:0] g);
		check_count++;
		if ((g >= l && g <= h) !== 1'h1) begin
			bad_count++;
			$display("mismatch %s expected %0h..%0h seen %0h", nm, l, h, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] x);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, x};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rcnt();
		rd(CTP_OFF_COUNT_HIGH);
		v[15:8] = d[7:0];
		rd(CTP_OFF_COUNT_LOW);
		v[7:0] = d[7:0];
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
		{bad_count, check_count, cyc} = 96'h0;
		aresetn = 1'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 7; i++) begin
			rd(6'(i * 4));
			chk("reset value", 32'h0, 32'h0, d);
		end
		rd(6'h20);
		chk("unmapped read resp", CTP_RESP_SLVERR, CTP_RESP_SLVERR, r);
		wr(6'h24, 8'h5A);
		chk("unmapped write resp", CTP_RESP_SLVERR, CTP_RESP_SLVERR, r);
		wr(CTP_OFF_CTRL_FIRST, 8'hFF);
		rd(CTP_OFF_CTRL_FIRST);
		chk("first control", 32'hF8, 32'hF8, d);
		wr(CTP_OFF_CTRL_FIRST, 8'h00);
		$display("test registers done");
		wr(CTP_OFF_CTRL_SECOND, 8'hC1);
		for (int s = 0; s < 8; s++) begin
			wr(CTP_OFF_CTRL_FIRST, {1'h0, 3'(s), 4'h8});
			if (s >= 6) begin
				u_pin.pulse(8);
				repeat (10) @(posedge aclk);
			end else begin
				repeat (200) @(posedge aclk);
			end
			wr(CTP_OFF_CTRL_FIRST, {1'h1, 3'(s), 4'h8});
			rcnt();
			chk("count per source", lo[s], hi[s], v);
			w = v;
			rcnt();
			chk("paused count", w, w, v);
			wr(CTP_OFF_CTRL_FIRST, 8'h00);
		end
		wr(CTP_OFF_COUNT_LOW, 8'h55);
		wr(CTP_OFF_COUNT_HIGH, 8'h55);
		rcnt();
		chk("count kept", 32'h8, 32'h8, v);
		$display("test clock sources done");
		wr(CTP_OFF_CMPA_LOW, 8'h20);
		wr(CTP_OFF_CMPA_HIGH, 8'h00);
		for (int k = 0; k < 16; k++) begin
			wr(CTP_OFF_CTRL_SECOND, {2'h0, k[1:0], k[2], k[3], 2'h1});
			wr(CTP_OFF_CTRL_FIRST, 8'h18);
			repeat (20) @(posedge aclk);
			chk("pin after on", k[2] ^ k[3], k[2] ^ k[3], board_level);
			repeat (30) @(posedge aclk);
			e = k[1] ? (k[0] ? ~k[2] : 1'h1) : (k[0] ? 1'h0 : k[2]);
			chk("pin after match", e ^ k[3], e ^ k[3], board_level);
			wr(CTP_OFF_CTRL_FIRST, 8'h00);
		end
		rd(CTP_OFF_FLAGS);
		chk("flags clear on a", 32'h1, 32'h1, d);
		wr(CTP_OFF_FLAGS, 8'h03);
		rd(CTP_OFF_FLAGS);
		chk("flags cleared", 32'h0, 32'h0, d);
		$display("test compare output done");
		wr(CTP_OFF_PERIOD, 8'h01);
		for (int j = 0; j < 4; j++) begin
			wr(CTP_OFF_CMPA_LOW, al[j]);
			wr(CTP_OFF_CMPA_HIGH, ah[j]);
			wr(CTP_OFF_CTRL_SECOND, {2'h2, fv[j], 1'h1, 1'h0, sw[j], 1'h0});
			wr(CTP_OFF_CTRL_FIRST, 8'h18);
			repeat (20) @(posedge aclk);
			n = 0;
			repeat (512) begin
				@(posedge aclk);
				if (board_level === 1'h1) n++;
			end
			chk("pwm active cycles", act[j] - act[j] / 32, act[j] + act[j] / 32, n);
			wr(CTP_OFF_CTRL_FIRST, 8'h00);
		end
		rd(CTP_OFF_CMPA_HIGH);
		chk("compare a high", 32'h2, 32'h2, d);
		$display("test pwm done");
		wr(CTP_OFF_FLAGS, 8'h03);
		wr(CTP_OFF_CTRL_SECOND, 8'h30);
		wr(CTP_OFF_CTRL_FIRST, 8'h18);
		repeat (300) @(posedge aclk);
		chk("pin held on p match", 32'h0, 32'h0, board_level);
		repeat (300) @(posedge aclk);
		wr(CTP_OFF_CTRL_FIRST, 8'h00);
		rd(CTP_OFF_FLAGS);
		chk("flags clear on p", 32'h2, 32'h2, d);
		rcnt();
		chk("count below period", 32'h0, 32'hFF, v);
		$display("test period clear done");
		results();
	end
endmodule
